// file: hdl/tsc_ctrl.sv
// Temperature conversion scheduling, result and average registers
`timescale 1ns/10ps
// Behaviour
// - Voltage straight binary, temperature twos complement
// - Voltage LSB is reference over 4096
// - Integration done starts temperature conversion
// - Command mode: temperature waits for voltage
// - Idle converter: temperature every 5 ms
// - Autocycle: at slot, else two cycles after voltage done; immediate when idle
// - Result register holds latest, always readable
// - Sensing and averaging only while enabled
// - Average is seven eighths old plus eighth new
// - First result reported directly after enable
// - Twelve bit twos complement, quarter degree
// - Reference select bit, internal after reset
// - Short low pin pulse resets registers
// - Long low pin means full power-down
// - Sixteen bit command, zero after reset
module tsc_ctrl (
  input wire logic sys_clk,                         // System clock, 40 MHz
  input wire logic reset,                           // Synchronous reset, active high
  input wire logic clkEnable,                       // Freezes all state when low
  input wire logic powerdown_reset_pin_n,           // Reset/power-down pin, active low
  input wire logic cmdWrite,                        // Command word write strobe
  input wire logic [15:0] cmdData,                  // Command word
  input wire logic voltStart,                       // Voltage conversion request
  input wire logic slotFree,                        // Autocycle sequence slot boundary
  input wire logic integrationDone,                 // Sensor integration period finished
  input wire logic adcDone,                         // Analog converter finished
  input wire logic [11:0] adcCode,                  // Raw converter code
  output logic adcStart,                            // Start a conversion pulse
  output logic adcSelTemp,                          // Conversion is on the temperature channel
  output logic externalReferenceSelect,             // External reference chosen
  output logic sensorEnable,                        // Temperature sensor powered
  output logic powerDown,                           // Full power-down level
  output logic [11:0] voltResult,                   // Voltage result, straight binary
  output logic [11:0] tempResult,                   // Temperature result, twos complement
  output logic [11:0] tempAverage,                  // Moving average of temperature
  output logic tempValid,                           // A temperature result is held
  output logic refReady                             // Reference settled after select change
);
  // ----------------------------------------
  // Pin decoder
  // ----------------------------------------
  tsc_pin_if pinBus();                              // Decoded pin events

  tsc_pin_decoder pinDecoder (
    .sys_clk(sys_clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .powerdown_reset_pin_n(powerdown_reset_pin_n),
    .pinBus(pinBus.decoder)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] cmd;                                 // Command register
  // Registers reset by reset, the pin reset pulse or the soft reset bit
  logic anyReset;                                   // Combined reset
  assign anyReset = reset | pinBus.pinResetPulse | cmd[tsc_pkg::CMD_SOFT_RST_BIT];
  tsc_pkg::tsc_state_e state;                       // Controller state
  logic tempPending;                                // Temperature conversion waiting
  logic [tsc_pkg::CNT_W-1:0] idleCount;             // Idle interval counter
  logic [tsc_pkg::CNT_W-1:0] refCount;              // Reference settle counter
  logic firstDone;                                  // First result since enable taken
  logic [14:0] avgAcc;                              // Average with three fraction bits

  logic [15:0] next_cmd;                            // Next command
  tsc_pkg::tsc_state_e next_state;                  // Next state
  logic next_tempPending;                           // Next pending flag
  logic [tsc_pkg::CNT_W-1:0] next_idleCount;        // Next idle count
  logic [tsc_pkg::CNT_W-1:0] next_refCount;         // Next settle count
  logic next_firstDone;                             // Next first flag
  logic [14:0] next_avgAcc;                         // Next average
  logic next_adcStart;                              // Next start pulse
  logic next_adcSelTemp;                            // Next channel select
  logic [11:0] next_voltResult;                     // Next voltage result
  logic [11:0] next_tempResult;                     // Next temperature result
  logic next_tempValid;                             // Next valid flag

  // Shift to accumulator width, appending three zero fraction bits
  function automatic logic [14:0] tsc_ext(input logic [11:0] v);
    tsc_ext = {v, 3'b000};
  endfunction : tsc_ext

  // Seven eighths of old plus one eighth of new, kept with fraction bits
  function automatic logic [14:0] tsc_avg(input logic [14:0] acc, input logic [11:0] v);
    logic signed [15:0] diff;
    diff = 16'(signed'({v[11], v, 3'b000})) - 16'(signed'({acc[14], acc}));
    tsc_avg = 15'(signed'({acc[14], acc}) + (diff >>> 3));
  endfunction : tsc_avg

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_cmd = cmd;
    next_state = state;
    next_tempPending = tempPending;
    next_idleCount = idleCount;
    next_refCount = refCount;
    next_firstDone = firstDone;
    next_avgAcc = avgAcc;
    next_adcStart = 1'b0;
    next_adcSelTemp = adcSelTemp;
    next_voltResult = voltResult;
    next_tempResult = tempResult;
    next_tempValid = tempValid;
    if (cmdWrite) begin
      next_cmd = cmdData;
      if (cmdData[tsc_pkg::CMD_EXTERNAL_REFERENCE_SELECT_BIT] != cmd[tsc_pkg::CMD_EXTERNAL_REFERENCE_SELECT_BIT]) begin
        next_refCount = '0;
      end
    end else if (refCount != tsc_pkg::CNT_W'(tsc_pkg::REF_SETTLE_CYC)) begin
      next_refCount = refCount + 1'b1;
    end
    // Sensor events only while enabled
    if (!cmd[tsc_pkg::CMD_TEMP_EN_BIT]) begin
      next_tempPending = 1'b0;
      next_firstDone = 1'b0;
      next_idleCount = '0;
    end else if (integrationDone) begin
      next_tempPending = 1'b1;
    end
    case (state)
      tsc_pkg::TSC_IDLE: begin
        if (cmd[tsc_pkg::CMD_TEMP_EN_BIT]) begin
          if (idleCount == tsc_pkg::CNT_W'(tsc_pkg::TEMP_INTERVAL_CYC - 1)) begin
            next_idleCount = '0;
            next_tempPending = 1'b1;
          end else begin
            next_idleCount = idleCount + 1'b1;
          end
        end
        if (tempPending && cmd[tsc_pkg::CMD_TEMP_EN_BIT]) begin
          next_state = tsc_pkg::TSC_TEMP;
          next_adcStart = 1'b1;
          next_adcSelTemp = 1'b1;
          next_tempPending = integrationDone;       // New event in the start cycle wins
          next_idleCount = '0;
        end else if (voltStart) begin
          next_state = tsc_pkg::TSC_VOLT;
          next_adcStart = 1'b1;
          next_adcSelTemp = 1'b0;
          next_idleCount = '0;
        end
      end
      tsc_pkg::TSC_VOLT: begin
        if (adcDone) begin
          next_voltResult = adcCode;
          // Pending temperature waits for the end of a voltage slot
          if (tempPending && cmd[tsc_pkg::CMD_TEMP_EN_BIT] &&
              (!cmd[tsc_pkg::CMD_AUTOCYCLE_BIT] || slotFree)) begin
            next_state = tsc_pkg::TSC_TEMP;
            next_adcStart = 1'b1;
            next_adcSelTemp = 1'b1;
            next_tempPending = integrationDone;     // New event in the start cycle wins
          end else begin
            next_state = tsc_pkg::TSC_IDLE;
          end
        end
      end
      tsc_pkg::TSC_TEMP: begin
        if (adcDone) begin
          next_state = tsc_pkg::TSC_IDLE;
          if (cmd[tsc_pkg::CMD_TEMP_EN_BIT]) begin
            next_tempResult = adcCode;
            next_tempValid = 1'b1;
            next_firstDone = 1'b1;
            next_avgAcc = firstDone ? tsc_avg(avgAcc, adcCode) : tsc_ext(adcCode);
          end
        end
      end
      tsc_pkg::TSC_DOWN: begin
        if (!pinBus.powerDown) begin
          next_state = tsc_pkg::TSC_IDLE;
        end
      end
      default: begin
        next_state = tsc_pkg::TSC_IDLE;
      end
    endcase
    if (pinBus.powerDown) begin
      next_state = tsc_pkg::TSC_DOWN;
      next_adcStart = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (anyReset) begin
      cmd <= tsc_pkg::CMD_RESET_VALUE;
      state <= tsc_pkg::TSC_IDLE;
      tempPending <= 1'b0;
      idleCount <= '0;
      refCount <= '0;
      firstDone <= 1'b0;
      avgAcc <= '0;
      adcStart <= 1'b0;
      adcSelTemp <= 1'b0;
      voltResult <= tsc_pkg::RES_RESET_VALUE;
      tempResult <= tsc_pkg::RES_RESET_VALUE;
      tempValid <= 1'b0;
    end else if (clkEnable) begin
      cmd <= next_cmd;
      state <= next_state;
      tempPending <= next_tempPending;
      idleCount <= next_idleCount;
      refCount <= next_refCount;
      firstDone <= next_firstDone;
      avgAcc <= next_avgAcc;
      adcStart <= next_adcStart;
      adcSelTemp <= next_adcSelTemp;
      voltResult <= next_voltResult;
      tempResult <= next_tempResult;
      tempValid <= next_tempValid;
    end
  end

  // Flopped views of command bits and status
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      externalReferenceSelect <= 1'b0;
      sensorEnable <= 1'b0;
      powerDown <= 1'b0;
      tempAverage <= tsc_pkg::RES_RESET_VALUE;
      refReady <= 1'b0;
    end else if (clkEnable) begin
      externalReferenceSelect <= next_cmd[tsc_pkg::CMD_EXTERNAL_REFERENCE_SELECT_BIT];
      sensorEnable <= next_cmd[tsc_pkg::CMD_TEMP_EN_BIT];
      powerDown <= pinBus.powerDown;
      tempAverage <= next_avgAcc[14:3];
      refReady <= (next_refCount == tsc_pkg::CNT_W'(tsc_pkg::REF_SETTLE_CYC));
    end
  end
endmodule : tsc_ctrl

// file: hdl/tsc_pkg.sv
// Constants and types for the temperature conversion controller
package tsc_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;                 // System clock rate
  localparam int TEMP_INTERVAL_US = 5000;           // Idle temperature conversion interval (5 ms)
  localparam int TEMP_INTERVAL_CYC = TEMP_INTERVAL_US * (CLK_HZ / 1000000); // Cycles per interval
  localparam int PIN_PULSE_MAX_NS = 100;            // Longest low pulse that still means reset
  localparam int PIN_PULSE_MAX_CYC = (PIN_PULSE_MAX_NS * (CLK_HZ / 1000000)) / 1000; // Rounded down
  localparam int REF_SETTLE_US = 5500;              // Reference buffer power-up time (5.5 ms)
  localparam int REF_SETTLE_CYC = REF_SETTLE_US * (CLK_HZ / 1000000); // Settling cycles
  localparam int CNT_W = 18;                        // Width of interval counters
  // ----------------------------------------
  // Command word fields
  // ----------------------------------------
  localparam int CMD_W = 16;                        // Command register width
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000; // Command register after power-up
  localparam int CMD_TEMP_EN_BIT = 7;               // Temperature enable bit
  localparam int CMD_EXTERNAL_REFERENCE_SELECT_BIT = 4;               // External reference select bit
  localparam int CMD_SOFT_RST_BIT = 1;              // Software reset bit
  localparam int CMD_AUTOCYCLE_BIT = 0;             // Autocycle mode bit
  // ----------------------------------------
  // Data widths
  // ----------------------------------------
  localparam int RES_W = 12;                        // Conversion result width
  localparam int VOLT_FULL_SCALE = 4096;            // Codes per reference span
  localparam int AVG_FRAC_W = 3;                    // Extra fraction bits of the average
  localparam logic [11:0] RES_RESET_VALUE = 12'h000; // Results after reset
  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TSC_IDLE  = 4'b0001,                            // Converter idle
    TSC_VOLT  = 4'b0010,                            // Voltage conversion running
    TSC_TEMP  = 4'b0100,                            // Temperature conversion running
    TSC_DOWN  = 4'b1000                             // Full power-down
  } tsc_state_e;
endpackage : tsc_pkg

// file: hdl/tsc_pin_if.sv
// Interface carrying power-down/reset pin decode results
`timescale 1ns/10ps
interface tsc_pin_if;
  logic pinResetPulse;                              // Short low pulse seen: reset registers
  logic powerDown;                                  // Long low level: full power-down
  modport decoder (output pinResetPulse, output powerDown);
  modport ctrl (input pinResetPulse, input powerDown);
endinterface : tsc_pin_if

// file: hdl/tsc_pin_decoder.sv
// Pulse-width decoder for the power-down/reset pin
`timescale 1ns/10ps
module tsc_pin_decoder (
  input wire logic sys_clk,                         // System clock
  input wire logic reset,                           // Synchronous reset
  input wire logic clkEnable,                       // Freezes state when low
  input wire logic powerdown_reset_pin_n,           // Raw pin, active low
  tsc_pin_if.decoder pinBus                         // Decoded events
);
  // ----------------------------------------
  // Synchroniser and width counter
  // ----------------------------------------
  logic pinMeta;                                    // First synchroniser stage
  logic pinSync;                                    // Second synchroniser stage
  logic [7:0] lowCount;                             // Cycles the pin has been low
  logic [7:0] next_lowCount;                        // Next low count
  logic next_reset;                                 // Next reset pulse
  logic next_down;                                  // Next power-down level
  logic resetPulse;                                 // Registered reset pulse
  logic downLevel;                                  // Registered power-down level

  // Width measure: pulse up to the limit resets, longer powers down
  always_comb begin
    next_lowCount = lowCount;
    next_reset = 1'b0;
    next_down = downLevel;
    if (!pinSync) begin
      if (lowCount != 8'hff) begin
        next_lowCount = lowCount + 8'h01;
      end
      if (32'(lowCount) >= tsc_pkg::PIN_PULSE_MAX_CYC) begin
        next_down = 1'b1;
      end
    end else begin
      next_lowCount = 8'h00;
      next_down = 1'b0;
      if (lowCount != 8'h00 && !downLevel) begin
        next_reset = 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
      lowCount <= 8'h00;
      resetPulse <= 1'b0;
      downLevel <= 1'b0;
    end else if (clkEnable) begin
      pinMeta <= powerdown_reset_pin_n;
      pinSync <= pinMeta;
      lowCount <= next_lowCount;
      resetPulse <= next_reset;
      downLevel <= next_down;
    end
  end

  assign pinBus.pinResetPulse = resetPulse;
  assign pinBus.powerDown = downLevel;
endmodule : tsc_pin_decoder

// file: sim/tsc_ctrl_assertions.sv
// Port checks for the temperature conversion controller
`timescale 1ns/10ps
module tsc_ctrl_assertions (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic powerdown_reset_pin_n, // Pin
  input wire logic cmdWrite, // Command strobe
  input wire logic [15:0] cmdData, // Command word
  input wire logic voltStart, // Voltage request
  input wire logic slotFree, // Slot boundary
  input wire logic integrationDone, // Integration end
  input wire logic adcDone, // Converter done
  input wire logic [11:0] adcCode, // Converter code
  input wire logic adcStart, // Start pulse
  input wire logic adcSelTemp, // Temp channel
  input wire logic externalReferenceSelect, // External_reference_select
  input wire logic sensorEnable, // Sensor on
  input wire logic powerDown, // Power-down
  input wire logic [11:0] voltResult, // Voltage result
  input wire logic [11:0] tempResult, // Temp result
  input wire logic [11:0] tempAverage, // Average
  input wire logic tempValid // Result held
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ------
  // Helper state
  // ------
  logic busy, busyTemp, pendTemp, firstTemp, enPrev, landed; // Conversion tracking
  logic [3:0] lowLen; // Consecutive pin lows
  logic [17:0] idleCnt; // Cycles since last start
  // Track conversions, pending requests and pin lows
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy <= 1'b0;
      busyTemp <= 1'b0;
      pendTemp <= 1'b0;
      firstTemp <= 1'b0;
      enPrev <= 1'b0;
      landed <= 1'b0;
      lowLen <= 4'h0;
      idleCnt <= 18'h00000;
    end else begin
      enPrev <= sensorEnable;
      landed <= adcDone && busy && busyTemp;
      if (adcStart) begin
        busy <= 1'b1;
        busyTemp <= adcSelTemp;
      end else if (adcDone) busy <= 1'b0;
      if (sensorEnable && !enPrev) firstTemp <= 1'b1;
      else if (adcDone && busy && busyTemp) firstTemp <= 1'b0;
      if ((adcStart && adcSelTemp) || !sensorEnable) pendTemp <= 1'b0;
      else if (integrationDone && busy) pendTemp <= 1'b1;
      lowLen <= powerdown_reset_pin_n ? 4'h0 : ((lowLen == 4'hf) ? lowLen : lowLen + 4'h1);
      idleCnt <= (adcStart || !sensorEnable || powerDown) ? 18'h00000 : idleCnt + 18'h00001;
    end
  end
  // ------
  // Assertions
  // ------
  a_temp_enabled: assert property (adcStart && adcSelTemp |-> sensorEnable || $past(sensorEnable))
    else $error("temperature conversion with sensor off");
  a_idle_start: assert property (integrationDone && sensorEnable && !busy && !adcStart && !pendTemp
    && !powerDown && powerdown_reset_pin_n && !voltStart && !cmdWrite |-> ##[1:4] (adcStart && adcSelTemp))
    else $error("idle temperature conversion did not start");
  a_after_volt: assert property (adcDone && busy && !busyTemp && pendTemp && slotFree
    |-> ##[1:4] (adcStart && adcSelTemp))
    else $error("pending temperature conversion not started after voltage");
  a_temp_result: assert property (adcDone && busy && busyTemp |=>
    tempResult == $past(adcCode) && tempValid)
    else $error("temperature result not loaded");
  a_volt_result: assert property (adcDone && busy && !busyTemp |=> voltResult == $past(adcCode)
    && $stable(tempResult))
    else $error("voltage result wrong or temperature disturbed");
  a_avg_first: assert property (adcDone && busy && busyTemp && firstTemp |=> tempAverage == $past(adcCode))
    else $error("first average not seeded by result");
  a_avg_update: assert property ($changed(tempAverage) && sensorEnable && $past(sensorEnable, 2) |-> landed)
    else $error("average changed without temperature result");
  a_cmd_fields: assert property (cmdWrite && !cmdData[1] && powerdown_reset_pin_n |=>
    sensorEnable == $past(cmdData[7]) && externalReferenceSelect == $past(cmdData[4]))
    else $error("command fields not applied");
  a_long_low: assert property (!powerdown_reset_pin_n [*8] |-> ##[0:4] powerDown)
    else $error("long pin low did not power down");
  a_short_nodown: assert property ($rose(powerdown_reset_pin_n) && lowLen inside {[4'h1:4'h3]}
    |-> !powerDown [*6])
    else $error("short pin pulse powered down");
  a_pin_clears: assert property ($rose(powerdown_reset_pin_n) && lowLen inside {[4'h1:4'h3]}
    |-> ##[1:8] (!sensorEnable && !externalReferenceSelect))
    else $error("short pin pulse did not clear command");
  a_interval: assert property (int'(idleCnt) <= tsc_pkg::TEMP_INTERVAL_CYC + 64)
    else $error("idle temperature interval exceeded");
  c_temp_start: cover property (adcStart && adcSelTemp);
  c_volt_done: cover property (adcDone && busy && !busyTemp);
  c_power_down: cover property ($rose(powerDown));
endmodule : tsc_ctrl_assertions
bind tsc_ctrl tsc_ctrl_assertions u_chk (.sys_clk(sys_clk), .reset(reset),
  .powerdown_reset_pin_n(powerdown_reset_pin_n), .cmdWrite(cmdWrite), .cmdData(cmdData), .voltStart(voltStart),
  .slotFree(slotFree), .integrationDone(integrationDone), .adcDone(adcDone), .adcCode(adcCode),
  .adcStart(adcStart), .adcSelTemp(adcSelTemp), .externalReferenceSelect(externalReferenceSelect),
  .sensorEnable(sensorEnable), .powerDown(powerDown), .voltResult(voltResult), .tempResult(tempResult),
  .tempAverage(tempAverage), .tempValid(tempValid));

// file: sim/tsc_adc_model.sv
// Behavioural converter answering the controller's start pulses
`timescale 1ns/10ps
module tsc_adc_model (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic adcStart, // Start pulse
  input wire logic adcSelTemp, // Temp channel
  input wire logic [4:0] lat, // Cycles to answer
  input wire logic [11:0] codeVolt, // Voltage code
  input wire logic [11:0] codeTemp, // Temperature code
  output logic adcDone = 1'b0, // Done pulse
  output logic [11:0] adcCode = 12'h000 // Valid with done only
);
  logic [4:0] cnt; // Cycles left
  logic selTemp; // Channel in flight
  // Count down and answer once
  always @(posedge sys_clk) begin
    adcDone <= 1'b0;
    adcCode <= ~adcCode; // Stale code changes every cycle
    if (reset) begin
      cnt <= 5'h00;
    end else if (adcStart) begin
      cnt <= lat;
      selTemp <= adcSelTemp;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        adcDone <= 1'b1;
        adcCode <= selTemp ? codeTemp : codeVolt;
      end
    end
  end
endmodule : tsc_adc_model

// file: sim/tb_temp_sensor_conversion_ctrl.sv
// Self-checking bench for the temperature conversion controller
`timescale 1ns/10ps
module tb_temp_sensor_conversion_ctrl;
  typedef struct {logic isTemp; logic [11:0] code; logic [11:0] avg; logic chkAvg;} tsc_exp_s; // Expectation
  tsc_exp_s expQ[$]; // Pending expectations
  tsc_exp_s e; // Entry under check
  logic sys_clk = 1'b0; // Clock
  logic reset = 1'b1; // Sync reset
  logic powerdown_reset_pin_n = 1'b1; // Pin, always driven
  logic cmdWrite = 1'b0, voltStart = 1'b0, slotFree = 1'b1, integrationDone = 1'b0; // Requests
  logic [15:0] cmdData = 16'h0000; // Command word
  logic [11:0] codeVolt = 12'h000, codeTemp = 12'h000, c0, c1; // Codes
  logic [4:0] lat = 5'h01; // Model latency
  logic adcStart, adcSelTemp, extRef, sensorEnable, powerDown, tempValid, adcDone, startSel, refReady; // Outputs
  logic [11:0] voltResult, tempResult, tempAverage, adcCode, lastTemp = 12'h000; // Results
  logic doneSeen = 1'b0; // Result lands this edge
  int n_mismatch = 0, comparisons = 0, nTempStart = 0, i; // Counters
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  tsc_ctrl dut (.sys_clk(sys_clk), .reset(reset), .clkEnable(1'b1), .powerdown_reset_pin_n(powerdown_reset_pin_n),
    .cmdWrite(cmdWrite), .cmdData(cmdData), .voltStart(voltStart), .slotFree(slotFree),
    .integrationDone(integrationDone), .adcDone(adcDone), .adcCode(adcCode), .adcStart(adcStart),
    .adcSelTemp(adcSelTemp), .externalReferenceSelect(extRef), .sensorEnable(sensorEnable),
    .powerDown(powerDown), .voltResult(voltResult), .tempResult(tempResult), .tempAverage(tempAverage),
    .tempValid(tempValid), .refReady(refReady));
  tsc_adc_model u_adc (.sys_clk(sys_clk), .reset(reset), .adcStart(adcStart), .adcSelTemp(adcSelTemp),
    .lat(lat), .codeVolt(codeVolt), .codeTemp(codeTemp), .adcDone(adcDone), .adcCode(adcCode));
  // ------
  // Tasks
  // ------
  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic write_cmd(logic [15:0] d);
    @(posedge sys_clk);
    cmdWrite <= 1'b1;
    cmdData <= d;
    tick(1);
    cmdWrite <= 1'b0;
    tick(2);
  endtask : write_cmd
  task automatic pulse_integ();
    @(posedge sys_clk);
    integrationDone <= 1'b1;
    tick(1);
    integrationDone <= 1'b0;
  endtask : pulse_integ
  task automatic run_temp(logic [11:0] c, logic [11:0] a, logic ca);
    codeTemp <= c;
    expQ.push_back('{1'b1, c, a, ca});
    pulse_integ();
  endtask : run_temp
  task automatic run_volt(logic [11:0] c);
    @(posedge sys_clk);
    codeVolt <= c;
    voltStart <= 1'b1;
    expQ.push_back('{1'b0, c, 12'h000, 1'b0});
    tick(1);
    voltStart <= 1'b0;
  endtask : run_volt
  task automatic drain();
    int k;
    for (k = 0; k < 300 && expQ.size() != 0; k++) @(posedge sys_clk);
    check("results outstanding", 12'h000, 12'(expQ.size()));
    tick(2);
  endtask : drain
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Pair each landed result with the oldest expectation
  always @(posedge sys_clk) begin
    doneSeen <= adcDone;
    if (adcStart === 1'b1) begin
      startSel <= adcSelTemp;
      nTempStart <= nTempStart + int'(adcSelTemp === 1'b1);
    end
    if (doneSeen === 1'b1) begin
      if (expQ.size() == 0) check("unexpected result", 12'h000, 12'h001);
      else begin
        e = expQ.pop_front();
        check("channel", {11'h000, e.isTemp}, {11'h000, startSel});
        if (e.isTemp) begin
          lastTemp = e.code;
          check("tempResult", e.code, tempResult);
          check("tempValid", 12'h001, {11'h000, tempValid});
          if (e.chkAvg) check("tempAverage", e.avg, tempAverage);
        end else begin
          check("voltResult", e.code, voltResult);
          check("tempResult held", lastTemp, tempResult);
        end
      end
    end
  end
  // Watchdog against a hang
  initial begin
    tick(20000);
    n_mismatch++;
    give_verdict();
  end
  // ------
  // Main sequence
  // ------
  initial begin
    void'($urandom(32'h7ffc06e1));
    tick(8);
    reset <= 1'b0;
    tick(2);
    check("sensorEnable", 12'h000, {11'h000, sensorEnable});
    check("externalReferenceSelect", 12'h000, {11'h000, extRef});
    pulse_integ();
    tick(10);
    check("temp starts while off", 12'h000, 12'(nTempStart));
    write_cmd(16'h0090);
    check("sensorEnable", 12'h001, {11'h000, sensorEnable});
    check("externalReferenceSelect", 12'h001, {11'h000, extRef});
    check("refReady", 12'h000, {11'h000, refReady});
    c0 = 12'($urandom_range(1023, 1));
    c1 = 12'($urandom_range(1023, 1));
    run_temp(c0, c0, 1'b1);
    drain();
    run_temp(c1, 12'((7 * int'(c0) + int'(c1)) / 8), 1'b1);
    drain();
    run_temp(12'hf60, 12'h000, 1'b0);
    drain();
    // Temperature request during a slow voltage conversion, command then autocycle
    lat <= 5'd20;
    for (i = 0; i < 2; i++) begin
      if (i == 1) write_cmd(16'h0091);
      run_volt(12'($urandom));
      tick(3);
      run_temp(12'($urandom_range(4095, 2048)), 12'h000, 1'b0);
      drain();
    end
    // Mixed traffic with random latency and slot state
    for (i = 0; i < 8; i++) begin
      lat <= 5'($urandom_range(16, 1));
      slotFree <= 1'($urandom);
      if ($urandom_range(1, 0) == 1) run_volt(12'($urandom));
      else run_temp(12'($urandom), 12'h000, 1'b0);
      drain();
    end
    // Short pin pulse clears the command, long low level powers down
    @(posedge sys_clk);
    powerdown_reset_pin_n <= 1'b0;
    tick(2);
    powerdown_reset_pin_n <= 1'b1;
    tick(10);
    check("sensorEnable after pulse", 12'h000, {11'h000, sensorEnable});
    check("extRef after pulse", 12'h000, {11'h000, extRef});
    check("powerDown after pulse", 12'h000, {11'h000, powerDown});
    powerdown_reset_pin_n <= 1'b0;
    tick(12);
    check("powerDown on long low", 12'h001, {11'h000, powerDown});
    powerdown_reset_pin_n <= 1'b1;
    tick(10);
    check("powerDown after release", 12'h000, {11'h000, powerDown});
    // Software reset bit clears the command word
    write_cmd(16'h0092);
    tick(1);
    check("sensorEnable after soft reset", 12'h000, {11'h000, sensorEnable});
    give_verdict();
  end
endmodule : tb_temp_sensor_conversion_ctrl
